// File: pkg/ors_pkg.sv
// Purpose: shared constants and types for the otg role swap and vbus sense block
// Assumes: 10 MHz module clock, 16-bit register port with byte offsets
// Notes: pin vector order below is the order of the synchroniser bits
package ors_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SUSPEND_IDLE_US = 3000;
  localparam int unsigned BUS_RESET_US = 10000;
  localparam int unsigned DEBOUNCE_NS = 2500;
  localparam int unsigned SUSPEND_CYCLES = SUSPEND_IDLE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RESET_CYCLES = (BUS_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG_TWO = 8'h04;
  localparam logic [7:0] ADDR_EVENTS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int CTRL_DPLUS = 0;
  localparam int CTRL_DMINUS = 1;
  localparam int CTRL_FULL_SPEED = 2;
  localparam int CTRL_HNP_ENABLE = 3;
  localparam int CTRL_A_DEVICE = 4;
  localparam int CTRL_VBUS_SUPPLY = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  localparam int CFG_CMP_DISABLE = 1;
  localparam int CFG_PINSET_SELECT = 5;
  localparam logic [1:0] CFG_RESET = 2'h0;

  localparam int EVT_BUS_RESET = 0;
  localparam int EVT_SUSPEND = 4;
  localparam int EVT_ATTACH = 6;
  localparam logic [15:0] EVT_MASK_BITS = 16'h0051;

  localparam int PIN_DP = 0;
  localparam int PIN_DM = 1;
  localparam int PIN_CMP_ONE = 2;
  localparam int PIN_CMP_TWO = 3;
  localparam int PIN_BUS_VALID = 4;
  localparam int PIN_SESS_VALID = 5;
  localparam int PIN_SESS_END = 6;
  localparam int PIN_COUNT = 7;

  typedef enum logic [1:0] {
    VB_BELOW_END,
    VB_END_TO_SESS,
    VB_SESS_TO_VALID,
    VB_ABOVE_VALID
  } ors_vbus_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_B_PERIPH,
    ST_B_WAIT_ACON,
    ST_B_HOST_RST,
    ST_B_HOST,
    ST_A_HOST_RST,
    ST_A_HOST,
    ST_A_PERIPH,
    ST_A_WAIT_BCON
  } ors_state_t;

endpackage

// File: src/ors_top.sv
// Purpose: dual-role role swap, pull-up control, line events and vbus level decode
// Assumes: line and comparator pins are asynchronous; register port on clk
// Notes: bus traffic itself is outside; this block gates it through host_traffic_enable
`timescale 1ns/1ps
module ors_top #(
  parameter int unsigned SUSPEND_CYCLES = ors_pkg::SUSPEND_CYCLES,
  parameter int unsigned RESET_CYCLES = ors_pkg::RESET_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic irq,
  input wire logic dp_in,
  input wire logic dm_in,
  output logic dp_out,
  output logic dp_oe,
  output logic dm_out,
  output logic dm_oe,
  output logic dplus_pullup,
  output logic dminus_pullup,
  output logic host_traffic_enable,
  output logic vbus_supply_enable,
  output logic internal_cmp_enable,
  input wire logic [1:0] internal_vbus_level,
  input wire logic cmp_state_in_one,
  input wire logic cmp_state_in_two,
  input wire logic bus_power_valid_in,
  input wire logic session_valid_in,
  input wire logic session_end_in,
  output logic [1:0] vbus_state
);

  localparam int CW = 17;
  localparam logic [CW-1:0] SUSP_MAX = CW'(SUSPEND_CYCLES - 1);
  localparam logic [CW-1:0] RST_MAX = CW'(RESET_CYCLES - 1);
  localparam logic [CW-1:0] DEB_MAX = CW'(ors_pkg::DEBOUNCE_CYCLES - 1);

  logic [5:0] ctrl_q;
  logic [1:0] cfg_q;
  logic [15:0] evt_q;
  logic [15:0] mask_q;
  logic [ors_pkg::PIN_COUNT-1:0] pins;
  logic [ors_pkg::PIN_COUNT-1:0] s1_q, s2_q, s3_q, pin_q;
  ors_pkg::ors_state_t state_q, state_d;
  ors_pkg::ors_vbus_t vbus_q;
  logic [2:0] ext_code;
  logic [CW-1:0] idle_cnt_q, se0_cnt_q, j_cnt_q, k_cnt_q, rst_cnt_q;
  logic suspended_q;
  logic line_se0, line_j, line_k;
  logic disc_seen, conn_seen, resume_seen, suspend_hit, rst_done;
  logic swap_ok;
  logic [15:0] evt_set;
  logic evt_clr;

  assign pins = {session_end_in, session_valid_in, bus_power_valid_in,
                 cmp_state_in_two, cmp_state_in_one, dm_in, dp_in};

  // three flops; a change is taken only once the last two agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ors_pkg::PIN_COUNT; gi++) begin : g_filt
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pin_q[gi] <= 1'b0;
        end else if (s2_q[gi] == s3_q[gi]) begin
          pin_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  assign line_se0 = !pin_q[ors_pkg::PIN_DP] && !pin_q[ors_pkg::PIN_DM];
  assign line_j = pin_q[ors_pkg::PIN_DP] && !pin_q[ors_pkg::PIN_DM];
  assign line_k = !pin_q[ors_pkg::PIN_DP] && pin_q[ors_pkg::PIN_DM];

  // decode of the external comparator pins; illegal codes keep the last level
  function automatic logic [2:0] decode_ext(input logic sel, input logic [4:0] p);
    logic [2:0] r;
    r = 3'h0;
    if (!sel) begin
      unique case ({p[1], p[0]})
        2'b00: r = {1'b1, 2'(ors_pkg::VB_BELOW_END)};
        2'b01: r = {1'b1, 2'(ors_pkg::VB_END_TO_SESS)};
        2'b10: r = {1'b1, 2'(ors_pkg::VB_SESS_TO_VALID)};
        2'b11: r = {1'b1, 2'(ors_pkg::VB_ABOVE_VALID)};
      endcase
    end else begin
      unique case ({p[2], p[3], p[4]})
        3'b001: r = {1'b1, 2'(ors_pkg::VB_BELOW_END)};
        3'b000: r = {1'b1, 2'(ors_pkg::VB_END_TO_SESS)};
        3'b010: r = {1'b1, 2'(ors_pkg::VB_SESS_TO_VALID)};
        3'b110: r = {1'b1, 2'(ors_pkg::VB_ABOVE_VALID)};
        default: r = 3'h0;
      endcase
    end
    return r;
  endfunction

  assign ext_code = decode_ext(cfg_q[1], pin_q[ors_pkg::PIN_SESS_END:ors_pkg::PIN_CMP_ONE]);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vbus_q <= ors_pkg::VB_BELOW_END;
      internal_cmp_enable <= 1'b1;
    end else begin
      internal_cmp_enable <= !cfg_q[0];
      if (!cfg_q[0]) begin
        vbus_q <= ors_pkg::ors_vbus_t'(internal_vbus_level);
      end else if (ext_code[2]) begin
        vbus_q <= ors_pkg::ors_vbus_t'(ext_code[1:0]);
      end
    end
  end

  // line timers; the connect timer restarts per state, a standing j is a new connect only after a full debounce
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_q <= '0;
      se0_cnt_q <= '0;
      j_cnt_q <= '0;
      k_cnt_q <= '0;
      suspended_q <= 1'b0;
    end else begin
      idle_cnt_q <= (line_j && !dp_oe && idle_cnt_q != SUSP_MAX) ? idle_cnt_q + 1'b1 :
                    (line_j && !dp_oe) ? idle_cnt_q : '0;
      suspended_q <= line_j && !dp_oe && idle_cnt_q == SUSP_MAX;
      se0_cnt_q <= (line_se0 && !dp_oe && se0_cnt_q != DEB_MAX) ? se0_cnt_q + 1'b1 :
                   (line_se0 && !dp_oe) ? se0_cnt_q : '0;
      j_cnt_q <= (!line_j || state_d != state_q) ? '0 :
                 (j_cnt_q != DEB_MAX) ? j_cnt_q + 1'b1 : j_cnt_q;
      k_cnt_q <= (line_k && k_cnt_q != DEB_MAX) ? k_cnt_q + 1'b1 : line_k ? k_cnt_q : '0;
    end
  end

  assign disc_seen = se0_cnt_q == DEB_MAX;
  assign conn_seen = j_cnt_q == DEB_MAX;
  assign resume_seen = k_cnt_q == DEB_MAX;
  assign suspend_hit = line_j && !dp_oe && idle_cnt_q == SUSP_MAX && !suspended_q;
  assign rst_done = rst_cnt_q == RST_MAX;
  assign swap_ok = ctrl_q[ors_pkg::CTRL_FULL_SPEED] && ctrl_q[ors_pkg::CTRL_HNP_ENABLE];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ors_pkg::ST_IDLE: begin
        if (vbus_q != ors_pkg::VB_BELOW_END) begin
          state_d = ctrl_q[ors_pkg::CTRL_A_DEVICE] ? ors_pkg::ST_A_HOST_RST
                                                   : ors_pkg::ST_B_PERIPH;
        end
      end
      ors_pkg::ST_B_PERIPH: begin
        if (swap_ok && suspended_q && !ctrl_q[ors_pkg::CTRL_DPLUS] &&
            !ctrl_q[ors_pkg::CTRL_DMINUS]) begin
          state_d = ors_pkg::ST_B_WAIT_ACON;
        end
      end
      ors_pkg::ST_B_WAIT_ACON: begin
        if (resume_seen) begin
          state_d = ors_pkg::ST_B_PERIPH;
        end else if (conn_seen) begin
          state_d = ors_pkg::ST_B_HOST_RST;
        end
      end
      ors_pkg::ST_B_HOST_RST: begin
        if (rst_done) begin
          state_d = ors_pkg::ST_B_HOST;
        end
      end
      ors_pkg::ST_B_HOST: begin
        if (ctrl_q[ors_pkg::CTRL_DPLUS]) begin
          state_d = ors_pkg::ST_B_PERIPH;
        end
      end
      ors_pkg::ST_A_HOST_RST: begin
        if (rst_done) begin
          state_d = ors_pkg::ST_A_HOST;
        end
      end
      ors_pkg::ST_A_HOST: begin
        if (swap_ok && disc_seen && ctrl_q[ors_pkg::CTRL_DPLUS]) begin
          state_d = ors_pkg::ST_A_PERIPH;
        end
      end
      ors_pkg::ST_A_PERIPH: begin
        if (suspend_hit) begin
          state_d = ors_pkg::ST_A_WAIT_BCON;
        end
      end
      ors_pkg::ST_A_WAIT_BCON: begin
        if (conn_seen) begin
          state_d = ors_pkg::ST_A_HOST_RST;
        end
      end
      default: state_d = ors_pkg::ST_IDLE;
    endcase
    // session end, e.g. supply switched off by the a-device
    if (vbus_q == ors_pkg::VB_BELOW_END) begin
      state_d = ors_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ors_pkg::ST_IDLE;
      rst_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      rst_cnt_q <= (state_d != state_q) ? '0 : rst_cnt_q + 1'b1;
    end
  end

  // pins; se0 held for the whole reset time before traffic is allowed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dp_out <= 1'b0;
      dm_out <= 1'b0;
      dp_oe <= 1'b0;
      dm_oe <= 1'b0;
      host_traffic_enable <= 1'b0;
      dplus_pullup <= 1'b0;
      dminus_pullup <= 1'b0;
      vbus_supply_enable <= 1'b0;
    end else begin
      dp_out <= 1'b0;
      dm_out <= 1'b0;
      dp_oe <= state_d == ors_pkg::ST_B_HOST_RST || state_d == ors_pkg::ST_A_HOST_RST;
      dm_oe <= state_d == ors_pkg::ST_B_HOST_RST || state_d == ors_pkg::ST_A_HOST_RST;
      host_traffic_enable <= state_d == ors_pkg::ST_B_HOST || state_d == ors_pkg::ST_A_HOST;
      // the a-device drops d+ on its own once suspend is seen, software may lag
      dplus_pullup <= ctrl_q[ors_pkg::CTRL_DPLUS] && state_d != ors_pkg::ST_A_WAIT_BCON &&
                      state_d != ors_pkg::ST_B_HOST && state_d != ors_pkg::ST_A_HOST;
      dminus_pullup <= ctrl_q[ors_pkg::CTRL_DMINUS];
      vbus_supply_enable <= ctrl_q[ors_pkg::CTRL_VBUS_SUPPLY];
    end
  end

  // register port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= ors_pkg::CTRL_RESET;
      cfg_q <= ors_pkg::CFG_RESET;
      mask_q <= '0;
    end else if (reg_write) begin
      if (reg_addr == ors_pkg::ADDR_CTRL) begin
        ctrl_q <= reg_wdata[5:0];
      end
      if (reg_addr == ors_pkg::ADDR_CONFIG_TWO) begin
        cfg_q <= {reg_wdata[ors_pkg::CFG_PINSET_SELECT], reg_wdata[ors_pkg::CFG_CMP_DISABLE]};
      end
      if (reg_addr == ors_pkg::ADDR_MASK) begin
        mask_q <= reg_wdata & ors_pkg::EVT_MASK_BITS;
      end
    end
  end

  always_comb begin
    evt_set = '0;
    evt_set[ors_pkg::EVT_BUS_RESET] = state_q == ors_pkg::ST_A_HOST && line_se0 && !dp_oe &&
                                      se0_cnt_q == DEB_MAX - 1'b1;
    evt_set[ors_pkg::EVT_ATTACH] = (state_q == ors_pkg::ST_B_WAIT_ACON && !resume_seen ||
                                    state_q == ors_pkg::ST_A_WAIT_BCON) && conn_seen;
    evt_set[ors_pkg::EVT_SUSPEND] = suspend_hit;
  end
  assign evt_clr = reg_read && reg_addr == ors_pkg::ADDR_EVENTS;

  // read clears the flags, an event in the same cycle still lands
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_q <= '0;
      irq <= 1'b0;
    end else begin
      evt_q <= (evt_clr ? 16'h0000 : evt_q) | evt_set;
      irq <= |(((evt_clr ? 16'h0000 : evt_q) | evt_set) & mask_q);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      unique case (reg_addr)
        ors_pkg::ADDR_CTRL: reg_rdata <= {10'h000, ctrl_q};
        ors_pkg::ADDR_CONFIG_TWO: reg_rdata <= {10'h000, cfg_q[1], 3'h0, cfg_q[0], 1'b0};
        ors_pkg::ADDR_EVENTS: reg_rdata <= evt_q;
        ors_pkg::ADDR_MASK: reg_rdata <= mask_q;
        ors_pkg::ADDR_STATUS: reg_rdata <= {4'h0, 4'(state_q), 1'b0, line_k, line_j,
                                            suspended_q, 2'(vbus_q), 2'h0};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  assign vbus_state = vbus_q;

  // checks
  property p_swap_gate;
    @(posedge clk) disable iff (!resetn)
    state_q == ors_pkg::ST_B_PERIPH && !swap_ok |=> state_q != ors_pkg::ST_B_WAIT_ACON;
  endproperty
  a_swap_gate: assert property (p_swap_gate) else $error("swap started without fs and hnp");

  property p_req_suspended;
    @(posedge clk) disable iff (!resetn)
    state_q == ors_pkg::ST_B_WAIT_ACON && $past(state_q) == ors_pkg::ST_B_PERIPH
      |-> $past(suspended_q) && $past(swap_ok);
  endproperty
  a_req_suspended: assert property (p_req_suspended) else $error("request while not suspended");

  property p_pullups_off;
    @(posedge clk) disable iff (!resetn)
    !ctrl_q[ors_pkg::CTRL_DPLUS] && !ctrl_q[ors_pkg::CTRL_DMINUS] |=> !dplus_pullup && !dminus_pullup;
  endproperty
  a_pullups_off: assert property (p_pullups_off) else $error("pull-up not released");

  property p_disc_flag;
    @(posedge clk) disable iff (!resetn)
    $rose(disc_seen) && $past(state_q) == ors_pkg::ST_A_HOST |-> evt_q[ors_pkg::EVT_BUS_RESET];
  endproperty
  a_disc_flag: assert property (p_disc_flag) else $error("disconnect not flagged");

  property p_resume_keeps;
    @(posedge clk) disable iff (!resetn)
    state_q == ors_pkg::ST_B_WAIT_ACON && resume_seen && vbus_q != ors_pkg::VB_BELOW_END
      |=> state_q == ors_pkg::ST_B_PERIPH;
  endproperty
  a_resume_keeps: assert property (p_resume_keeps) else $error("resume did not keep role");

  property p_attach_host;
    @(posedge clk) disable iff (!resetn)
    $rose(state_q == ors_pkg::ST_B_HOST_RST) |-> evt_q[ors_pkg::EVT_ATTACH];
  endproperty
  a_attach_host: assert property (p_attach_host) else $error("host taken without attach");

  property p_reset_first;
    @(posedge clk) disable iff (!resetn)
    $past(state_q) == ors_pkg::ST_B_HOST_RST && state_q == ors_pkg::ST_B_HOST_RST
      |-> dp_oe && dm_oe && !dp_out && !dm_out && !host_traffic_enable;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("traffic before bus reset");

  property p_suspend_drop;
    @(posedge clk) disable iff (!resetn)
    state_q == ors_pkg::ST_A_PERIPH && suspend_hit && vbus_q != ors_pkg::VB_BELOW_END
      |=> ##1 !dplus_pullup;
  endproperty
  a_suspend_drop: assert property (p_suspend_drop) else $error("d+ kept after suspend");

  property p_cmp_off;
    @(posedge clk) disable iff (!resetn)
    cfg_q[0] |=> !internal_cmp_enable;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("internal comparator still on");

  property p_two_pin;
    @(posedge clk) disable iff (!resetn)
    cfg_q == 2'b01 && pin_q[ors_pkg::PIN_CMP_TWO:ors_pkg::PIN_CMP_ONE] == 2'b01
      |=> vbus_q == ors_pkg::VB_END_TO_SESS;
  endproperty
  a_two_pin: assert property (p_two_pin) else $error("two-pin decode wrong");

  c_b_host: cover property (@(posedge clk) disable iff (!resetn) state_q == ors_pkg::ST_B_HOST);
  c_a_back: cover property (@(posedge clk) disable iff (!resetn)
    state_q == ors_pkg::ST_A_WAIT_BCON ##1 state_q == ors_pkg::ST_A_HOST_RST);
  c_resume: cover property (@(posedge clk) disable iff (!resetn)
    state_q == ors_pkg::ST_B_WAIT_ACON ##1 state_q == ors_pkg::ST_B_PERIPH);

endmodule

// File: verif/ors_peer.sv
// Purpose: far-side usb peer line driver and external vbus comparators
// Assumes: line_cmd 0 se0, 1 j, 2 k; level 0..3 as vbus_state
// Notes: unselected comparator pins toggle so a stale level never decodes right
`timescale 1ns/1ps
module ors_peer (
  input wire logic clk,
  input wire logic [1:0] line_cmd,
  input wire logic dp_out,
  input wire logic dp_oe,
  input wire logic dm_out,
  input wire logic dm_oe,
  input wire logic [1:0] level,
  input wire logic pinset,
  output logic dp_in,
  output logic dm_in,
  output logic cmp_one,
  output logic cmp_two,
  output logic bus_valid,
  output logic sess_valid,
  output logic sess_end
);
  logic tog = 1'b0;
  always @(posedge clk) begin
    tog <= ~tog;
  end
  // design enable wins the shared wire while it drives
  assign dp_in = dp_oe ? dp_out : (line_cmd == 2'h1);
  assign dm_in = dm_oe ? dm_out : (line_cmd == 2'h2);
  assign cmp_one = pinset ? tog : level[0];
  assign cmp_two = pinset ? ~tog : level[1];
  assign bus_valid = pinset ? (level == 2'h3) : tog;
  assign sess_valid = pinset ? level[1] : ~tog;
  assign sess_end = pinset ? (level == 2'h0) : tog;
endmodule

// File: verif/otg_role_swap_vbus_sense_bench.sv
// Purpose: self-checking bench for role swap, pull-ups, events and vbus decode
// Assumes: short counts, suspend 50 and bus reset 20 cycles
// Notes: every wait is bounded; a spent bound ends the run
`timescale 1ns/1ps
module otg_role_swap_vbus_sense_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic irq, dp_in, dm_in, dp_out, dp_oe, dm_out, dm_oe, dplus_pullup, dminus_pullup;
  logic host_traffic_enable, vbus_supply_enable, internal_cmp_enable;
  logic c1, c2, bv, sv, se;
  logic [1:0] internal_vbus_level = 2'h0;
  logic [1:0] vbus_state;
  logic [1:0] line_cmd = 2'h1;
  logic [1:0] level = 2'h0;
  logic pinset = 1'b0;
  logic [15:0] rv;
  int err_total = 0;
  int comparisons = 0;
  int n;
  always #50 clk = ~clk;

  ors_top #(.SUSPEND_CYCLES(50), .RESET_CYCLES(20)) ors_top_i (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
    .dp_in(dp_in), .dm_in(dm_in), .dp_out(dp_out), .dp_oe(dp_oe), .dm_out(dm_out),
    .dm_oe(dm_oe), .dplus_pullup(dplus_pullup), .dminus_pullup(dminus_pullup),
    .host_traffic_enable(host_traffic_enable), .vbus_supply_enable(vbus_supply_enable),
    .internal_cmp_enable(internal_cmp_enable), .internal_vbus_level(internal_vbus_level),
    .cmp_state_in_one(c1), .cmp_state_in_two(c2), .bus_power_valid_in(bv),
    .session_valid_in(sv), .session_end_in(se), .vbus_state(vbus_state));

  ors_peer ors_peer_i (
    .clk(clk), .line_cmd(line_cmd), .dp_out(dp_out), .dp_oe(dp_oe), .dm_out(dm_out),
    .dm_oe(dm_oe), .level(level), .pinset(pinset), .dp_in(dp_in), .dm_in(dm_in),
    .cmp_one(c1), .cmp_two(c2), .bus_valid(bv), .sess_valid(sv), .sess_end(se));

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return dp_oe;
      1: return host_traffic_enable;
      2: return dplus_pullup;
      default: return irq;
    endcase
  endfunction

  // counts negedges until the chosen output reaches v
  task automatic await(input int w, input logic v, input int bound);
    n = 0;
    while (pick(w) !== v) begin
      @(negedge clk);
      n++;
      if (n > bound) begin
        err_total++;
        $display("Error at %0t: output %0d got %h expected %h", $time, w, pick(w), v);
        conclude();
      end
    end
  endtask

  task automatic t_reset;
    rd(ors_pkg::ADDR_CTRL, rv);
    chk(rv, 16'h0000);
    chk({15'h0, internal_cmp_enable}, 16'h0001);
    rd(8'h40, rv);
    chk(rv, 16'h0000);
  endtask

  task automatic t_vbus;
    @(posedge clk);
    internal_vbus_level <= 2'h2;
    repeat (8) @(posedge clk);
    chk({14'h0, vbus_state}, 16'h0002);
    for (int p = 0; p < 2; p++) begin
      wr(ors_pkg::ADDR_CONFIG_TWO, p ? 16'h0022 : 16'h0002);
      for (int l = 0; l < 4; l++) begin
        @(posedge clk);
        pinset <= p[0];
        level <= l[1:0];
        @(negedge clk);
        if (l > 0) chk({14'h0, vbus_state}, 16'(l - 1));
        repeat (8) @(negedge clk);
        chk({14'h0, vbus_state}, 16'(l));
      end
    end
    chk({15'h0, internal_cmp_enable}, 16'h0000);
  endtask

  task automatic t_bswap;
    wr(ors_pkg::ADDR_CTRL, 16'h0005);
    repeat (70) @(posedge clk);
    wr(ors_pkg::ADDR_CTRL, 16'h0008);
    repeat (40) @(posedge clk);
    rd(ors_pkg::ADDR_STATUS, rv);
    chk({12'h0, rv[11:8]}, 16'h0001);
    wr(ors_pkg::ADDR_CTRL, 16'h0004);
    repeat (40) @(posedge clk);
    rd(ors_pkg::ADDR_STATUS, rv);
    chk({12'h0, rv[11:8]}, 16'h0001);
    chk({14'h0, dplus_pullup, dminus_pullup}, 16'h0000);
    wr(ors_pkg::ADDR_CTRL, 16'h000c);
    rd(ors_pkg::ADDR_STATUS, rv);
    chk({12'h0, rv[11:8]}, 16'h0002);
    @(posedge clk);
    line_cmd <= 2'h2;
    repeat (40) @(posedge clk);
    rd(ors_pkg::ADDR_STATUS, rv);
    chk({12'h0, rv[11:8]}, 16'h0001);
    rd(ors_pkg::ADDR_EVENTS, rv);
    chk(rv & 16'h0040, 16'h0000);
    @(posedge clk);
    line_cmd <= 2'h1;
    await(0, 1'b1, 200);
    chk({12'h0, dm_oe, dp_out, dm_out, host_traffic_enable}, 16'h0008);
    await(1, 1'b1, 60);
    chk({15'h0, n >= 19}, 16'h0001);
    rd(ors_pkg::ADDR_EVENTS, rv);
    chk(rv & 16'h0040, 16'h0040);
    wr(ors_pkg::ADDR_CTRL, 16'h000d);
    await(1, 1'b0, 8);
    await(2, 1'b1, 8);
  endtask

  task automatic t_aswap;
    @(posedge clk);
    level <= 2'h0;
    wr(ors_pkg::ADDR_CTRL, 16'h003c);
    wr(ors_pkg::ADDR_MASK, 16'h0001);
    @(posedge clk);
    level <= 2'h3;
    await(1, 1'b1, 80);
    chk({15'h0, vbus_supply_enable}, 16'h0001);
    @(posedge clk);
    line_cmd <= 2'h0;
    await(3, 1'b1, 60);
    rd(ors_pkg::ADDR_EVENTS, rv);
    chk(rv & 16'h0001, 16'h0001);
    await(3, 1'b0, 4);
    wr(ors_pkg::ADDR_MASK, 16'h0000);
    wr(ors_pkg::ADDR_CTRL, 16'h003d);
    await(2, 1'b1, 8);
    @(posedge clk);
    line_cmd <= 2'h1;
    await(2, 1'b0, 120);
    chk({15'h0, n >= 45}, 16'h0001);
    await(0, 1'b1, 60);
    chk({14'h0, dp_out, dm_out}, 16'h0000);
    rd(ors_pkg::ADDR_EVENTS, rv);
    chk(rv & 16'h0050, 16'h0050);
    chk({15'h0, irq}, 16'h0000);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_vbus();
    t_bswap();
    t_aswap();
    conclude();
  end
endmodule
